/* File: rtl/pafs_defines.vh */
`ifndef PAFS_DEFINES_VH
`define PAFS_DEFINES_VH

// register index: byte address is four times the index (low 30 bits)
`define PAFS_DIR_IDX      32'hffff8387
`define PAFS_CTRL_IDX     32'hffff838c

// reset values
`define PAFS_DIR_RST      16'h0000
`define PAFS_CTRL_RST     16'h0000

// writable bits, full and reduced-pin variants
`define PAFS_DIR_WMASK    16'hffff
`define PAFS_DIR_WMASK_R  16'h83ff
`define PAFS_CTRL_WMASK   16'h555f
`define PAFS_CTRL_WMASK_R 16'h400f

// function control field positions
`define PAFS_L15_BIT      14
`define PAFS_L14_BIT      12
`define PAFS_L13_BIT      10
`define PAFS_L12_BIT      8
`define PAFS_L11_BIT      6
`define PAFS_L10_BIT      4
`define PAFS_L9_HI        3
`define PAFS_L9_LO        2
`define PAFS_L8_HI        1
`define PAFS_L8_LO        0

// two-bit field codes for lines 9 and 8
`define PAFS_FN_GPIO      2'h0
`define PAFS_FN_TCLK      2'h1
`define PAFS_FN_IRQ       2'h2
`define PAFS_FN_RSVD      2'h3

// port line numbers
`define PAFS_LINE15       15
`define PAFS_LINE14       14
`define PAFS_LINE13       13
`define PAFS_LINE12       12
`define PAFS_LINE11       11
`define PAFS_LINE10       10
`define PAFS_LINE9        9
`define PAFS_LINE8        8

`endif

/* File: rtl/pafs_pin_drv.v */
`timescale 1ns/10ps
`default_nettype none

// per-line pin driver: registered pin output, enable and input sample
module pafs_pin_drv #(
   parameter LINES = 16
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire [LINES-1:0] func_en_i,
   input  wire [LINES-1:0] func_dout_i,
   input  wire [LINES-1:0] func_oe_i,
   input  wire [LINES-1:0] dir_i,
   input  wire [LINES-1:0] gpio_dout_i,
   input  wire [LINES-1:0] pin_i,
   output reg  [LINES-1:0] pin_o,
   output reg  [LINES-1:0] pin_oe_o,
   output reg  [LINES-1:0] gpio_din_o
);

   genvar g;

   generate
      for (g = 0; g < LINES; g = g + 1) begin : g_line
         always @(posedge clk_i) begin
            if (rst_i) begin
               // all lines float as inputs while in reset
               pin_o[g]      <= 1'b0;
               pin_oe_o[g]   <= 1'b0;
               gpio_din_o[g] <= 1'b0;
            end else begin
               gpio_din_o[g] <= pin_i[g];
               if (func_en_i[g]) begin
                  pin_o[g]    <= func_dout_i[g];
                  pin_oe_o[g] <= func_oe_i[g];
               end else begin
                  pin_o[g]    <= gpio_dout_i[g];
                  pin_oe_o[g] <= dir_i[g];
               end
            end
         end
      end
   endgenerate

endmodule // pafs_pin_drv

`default_nettype wire

/* File: rtl/pafs_top.v */
// Notes on behaviour
// - 16-bit direction register, one bit per line, reset zero, byte lanes.
// - 16-bit upper function register; odd bits 5 to 15 read only.
// - bit 14 zero gives general line 15, one gives clock output.
// - bit 14 resets to one in extended mode; other bits reset zero.
// - bit 12 one drives read strobe on line 14, not single-chip.
// - with ROM disabled, bits 12..4 zero still give bus functions.
// - bit 10 one drives upper-byte write strobe on line 13.
// - bit 8 one drives lower-byte write strobe on line 12.
// - bit 6 one drives chip select one on line 11.
// - bit 4 one drives chip select zero on line 10.
// - bits 3:2 pick line 9: gpio, timer clock d, interrupt 3.
// - bits 1:0 pick line 8: gpio, timer clock c, interrupt 2.
// - reduced-pin variant reserves direction bits 14..10 and function bits 12..4.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "pafs_defines.vh"

module pafs_top #(
   parameter LINES       = 16,
   parameter REDUCED_PIN = 0
) (
   input  wire             clk_i,
   input  wire             rst_i,
   // classic wishbone slave
   input  wire             cyc_i,
   input  wire             stb_i,
   input  wire             we_i,
   input  wire [31:0]      adr_i,
   input  wire [3:0]       sel_i,
   input  wire [31:0]      dat_i,
   output reg  [31:0]      dat_o,
   output reg              ack_o,
   // chip operating mode
   input  wire             ext_mode_i,
   input  wire             rom_off_i,
   // port pins
   input  wire [LINES-1:0] pin_i,
   output wire [LINES-1:0] pin_o,
   output wire [LINES-1:0] pin_oe_o,
   // general input/output data
   input  wire [LINES-1:0] gpio_dout_i,
   output wire [LINES-1:0] gpio_din_o,
   // peripheral outputs routed onto pins
   input  wire             sys_clock_out_i,
   input  wire             read_strobe_i,
   input  wire             upper_byte_write_strobe_i,
   input  wire             lower_byte_write_strobe_i,
   input  wire             chip_select_one_i,
   input  wire             chip_select_zero_i,
   // peripheral inputs taken from pins
   output reg              timer_ext_clock_d_o,
   output reg              timer_ext_clock_c_o,
   output reg              ext_interrupt_3_o,
   output reg              ext_interrupt_2_o
);

   localparam [15:0] DIR_WMASK  = (REDUCED_PIN != 0) ?
                                  `PAFS_DIR_WMASK_R : `PAFS_DIR_WMASK;
   localparam [15:0] CTRL_WMASK = (REDUCED_PIN != 0) ?
                                  `PAFS_CTRL_WMASK_R : `PAFS_CTRL_WMASK;
   localparam [31:0] DIR_IDX    = `PAFS_DIR_IDX;
   localparam [31:0] CTRL_IDX   = `PAFS_CTRL_IDX;

   reg  [15:0]      dir_q;
   reg  [15:0]      dir_d;
   reg  [15:0]      ctrl_q;
   reg  [15:0]      ctrl_d;
   reg  [31:0]      rdata_d;
   reg              ack_d;
   reg  [15:0]      lane_mask;
   wire             req;
   wire             hit_dir;
   wire             hit_ctrl;
   wire             bus_mode;
   reg  [LINES-1:0] func_en;
   reg  [LINES-1:0] func_dout;
   reg  [LINES-1:0] func_oe;
   wire [1:0]       l9_sel;
   wire [1:0]       l8_sel;
   wire [15:0]      dir_ext;

   // one request per handshake; ack drops the cycle after it rose
   assign req      = cyc_i & stb_i & ~ack_o;
   assign hit_dir  = (adr_i[31:2] == DIR_IDX[29:0]);
   assign hit_ctrl = (adr_i[31:2] == CTRL_IDX[29:0]);

   // on-chip ROM disabled implies an external bus is present
   assign bus_mode    = ext_mode_i | rom_off_i;

   assign l9_sel = {ctrl_q[`PAFS_L9_HI], ctrl_q[`PAFS_L9_LO]};
   assign l8_sel = {ctrl_q[`PAFS_L8_HI], ctrl_q[`PAFS_L8_LO]};

   // byte lanes of the low halfword
   always @* begin
      lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
   end

   // register write path
   always @* begin
      dir_d  = dir_q;
      ctrl_d = ctrl_q;
      if (req && we_i) begin
         if (hit_dir) begin
            dir_d = (dir_q & ~(lane_mask & DIR_WMASK)) |
                    (dat_i[15:0] & lane_mask & DIR_WMASK);
         end else if (hit_ctrl) begin
            ctrl_d = (ctrl_q & ~(lane_mask & CTRL_WMASK)) |
                     (dat_i[15:0] & lane_mask & CTRL_WMASK);
         end
      end
   end

   // read path; unmapped addresses answer with zero
   always @* begin
      rdata_d = 32'h00000000;
      if (hit_dir) begin
         rdata_d = {16'h0000, dir_q & DIR_WMASK};
      end else if (hit_ctrl) begin
         rdata_d = {16'h0000, ctrl_q & CTRL_WMASK};
      end
   end

   always @* begin
      ack_d = req;
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dir_q  <= `PAFS_DIR_RST;
         ctrl_q <= `PAFS_CTRL_RST;
         // clock output on by default in extended mode
         ctrl_q[`PAFS_L15_BIT] <= ext_mode_i;
         ack_o  <= 1'b0;
         dat_o  <= 32'h00000000;
      end else begin
         dir_q  <= dir_d;
         ctrl_q <= ctrl_d;
         ack_o  <= ack_d;
         if (req) begin
            dat_o <= rdata_d;
         end
      end
   end

   // pin function decode
   always @* begin
      func_en   = {LINES{1'b0}};
      func_dout = {LINES{1'b0}};
      func_oe   = {LINES{1'b0}};

      // line 15: clock out in any mode
      if (ctrl_q[`PAFS_L15_BIT]) begin
         func_en[`PAFS_LINE15]   = 1'b1;
         func_dout[`PAFS_LINE15] = sys_clock_out_i;
         func_oe[`PAFS_LINE15]   = 1'b1;
      end

      // lines 14..10 are bus pins only outside single-chip mode
      if (REDUCED_PIN == 0) begin
         if (bus_mode && (ctrl_q[`PAFS_L14_BIT] || rom_off_i)) begin
            func_en[`PAFS_LINE14]   = 1'b1;
            func_dout[`PAFS_LINE14] = read_strobe_i;
            func_oe[`PAFS_LINE14]   = 1'b1;
         end
         if (bus_mode && (ctrl_q[`PAFS_L13_BIT] || rom_off_i)) begin
            func_en[`PAFS_LINE13]   = 1'b1;
            func_dout[`PAFS_LINE13] = upper_byte_write_strobe_i;
            func_oe[`PAFS_LINE13]   = 1'b1;
         end
         if (bus_mode && (ctrl_q[`PAFS_L12_BIT] || rom_off_i)) begin
            func_en[`PAFS_LINE12]   = 1'b1;
            func_dout[`PAFS_LINE12] = lower_byte_write_strobe_i;
            func_oe[`PAFS_LINE12]   = 1'b1;
         end
         if (bus_mode && (ctrl_q[`PAFS_L11_BIT] || rom_off_i)) begin
            func_en[`PAFS_LINE11]   = 1'b1;
            func_dout[`PAFS_LINE11] = chip_select_one_i;
            func_oe[`PAFS_LINE11]   = 1'b1;
         end
         if (bus_mode && (ctrl_q[`PAFS_L10_BIT] || rom_off_i)) begin
            func_en[`PAFS_LINE10]   = 1'b1;
            func_dout[`PAFS_LINE10] = chip_select_zero_i;
            func_oe[`PAFS_LINE10]   = 1'b1;
         end
      end

      // lines 9 and 8: input functions, pin left undriven
      // reserved code falls back to general input/output
      case (l9_sel)
         `PAFS_FN_TCLK: begin
            func_en[`PAFS_LINE9] = 1'b1;
         end
         `PAFS_FN_IRQ: begin
            func_en[`PAFS_LINE9] = 1'b1;
         end
         default: begin
            func_en[`PAFS_LINE9] = 1'b0;
         end
      endcase
      case (l8_sel)
         `PAFS_FN_TCLK: begin
            func_en[`PAFS_LINE8] = 1'b1;
         end
         `PAFS_FN_IRQ: begin
            func_en[`PAFS_LINE8] = 1'b1;
         end
         default: begin
            func_en[`PAFS_LINE8] = 1'b0;
         end
      endcase
   end

   // peripheral inputs: pin sample, held low when not selected
   always @(posedge clk_i) begin
      if (rst_i) begin
         timer_ext_clock_d_o <= 1'b0;
         ext_interrupt_3_o   <= 1'b0;
         timer_ext_clock_c_o <= 1'b0;
         ext_interrupt_2_o   <= 1'b0;
      end else begin
         timer_ext_clock_d_o <= (l9_sel == `PAFS_FN_TCLK) &
                                pin_i[`PAFS_LINE9];
         ext_interrupt_3_o   <= (l9_sel == `PAFS_FN_IRQ) &
                                pin_i[`PAFS_LINE9];
         timer_ext_clock_c_o <= (l8_sel == `PAFS_FN_TCLK) &
                                pin_i[`PAFS_LINE8];
         ext_interrupt_2_o   <= (l8_sel == `PAFS_FN_IRQ) &
                                pin_i[`PAFS_LINE8];
      end
   end

   // reserved direction bits act as inputs
   assign dir_ext = dir_q & DIR_WMASK;

   pafs_pin_drv #(
      .LINES       (LINES)
   ) u_pin_drv (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .func_en_i   (func_en),
      .func_dout_i (func_dout),
      .func_oe_i   (func_oe),
      .dir_i       (dir_ext[LINES-1:0]),
      .gpio_dout_i (gpio_dout_i),
      .pin_i       (pin_i),
      .pin_o       (pin_o),
      .pin_oe_o    (pin_oe_o),
      .gpio_din_o  (gpio_din_o)
   );

endmodule // pafs_top

`default_nettype wire

/* File: verif/pafs_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module pafs_top_asserts #(
   parameter LINES       = 16,
   parameter REDUCED_PIN = 0
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             cyc_i,
   input wire logic             stb_i,
   input wire logic             ack_o,
   input wire logic [31:0]      dat_o,
   input wire logic             rom_off_i,
   input wire logic             read_strobe_i,
   input wire logic [LINES-1:0] pin_i,
   input wire logic [LINES-1:0] pin_o,
   input wire logic [LINES-1:0] pin_oe_o,
   input wire logic [LINES-1:0] gpio_dout_i,
   input wire logic [LINES-1:0] gpio_din_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_taken: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("request not acked next cycle");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_dat_upper: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_reset_clear: assert property ($past(rst_i) |-> !ack_o &&
      pin_oe_o == '0) else $error("outputs not cleared by reset");
   // rom off overrides the control bits, so no register state needed here
   a_bus_route: assert property (REDUCED_PIN == 0 && !$past(rst_i)
      && $past(rom_off_i) |-> pin_oe_o[14:10] == 5'h1f &&
      pin_o[14] == $past(read_strobe_i))
      else $error("bus functions not routed");
   // reduced-pin variant never drives the reserved lines
   a_rsv_float: assert property (REDUCED_PIN != 0 && !$past(rst_i) |->
      pin_oe_o[14:10] == 5'h00) else $error("reserved lines driven");
   a_low_gpio: assert property (!$past(rst_i) |->
      (pin_o[7:0] & pin_oe_o[7:0]) ==
      ($past(gpio_dout_i[7:0]) & pin_oe_o[7:0]))
      else $error("low line drive wrong");
   a_din_sample: assert property (!$past(rst_i) |->
      gpio_din_o == $past(pin_i)) else $error("input sample wrong");
endmodule // pafs_top_asserts
bind pafs_top pafs_top_asserts #(.LINES(LINES), .REDUCED_PIN(REDUCED_PIN))
   pafs_top_asserts_inst (
   .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .ack_o(ack_o), .dat_o(dat_o), .rom_off_i(rom_off_i),
   .read_strobe_i(read_strobe_i), .pin_i(pin_i), .pin_o(pin_o),
   .pin_oe_o(pin_oe_o), .gpio_dout_i(gpio_dout_i), .gpio_din_o(gpio_din_o));
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((e) !== (g)) begin \
   miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb_top;
   localparam DIR = 32'hfffe0e1c;
   localparam CTL = 32'hfffe0e30;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, ext_i, rom_i;
   logic [31:0] adr_i, dat_i, dat_o, q;
   logic [3:0]  sel_i, fn;
   logic [15:0] pin_i, pin_o, pin_oe_o, dout, din, oe2;
   logic [31:0] dat_o2, q2;
   logic [3:0]  efn;
   logic [5:0]  per;
   int          miscompares, checks_done;
   pafs_top pafs_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ext_mode_i(ext_i),
      .rom_off_i(rom_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .gpio_dout_i(dout), .gpio_din_o(din), .sys_clock_out_i(per[5]),
      .read_strobe_i(per[4]), .upper_byte_write_strobe_i(per[3]),
      .lower_byte_write_strobe_i(per[2]), .chip_select_one_i(per[1]),
      .chip_select_zero_i(per[0]), .timer_ext_clock_d_o(fn[3]),
      .ext_interrupt_3_o(fn[2]), .timer_ext_clock_c_o(fn[1]),
      .ext_interrupt_2_o(fn[0]));
   // reduced-pin variant shares the bus; its ack matches the main one
   pafs_top #(.REDUCED_PIN(1)) pafs_top_rp_inst (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o2),
      .ack_o(), .ext_mode_i(ext_i), .rom_off_i(rom_i), .pin_i(pin_i),
      .pin_o(), .pin_oe_o(oe2), .gpio_dout_i(dout), .gpio_din_o(),
      .sys_clock_out_i(per[5]), .read_strobe_i(per[4]),
      .upper_byte_write_strobe_i(per[3]),
      .lower_byte_write_strobe_i(per[2]), .chip_select_one_i(per[1]),
      .chip_select_zero_i(per[0]), .timer_ext_clock_d_o(),
      .ext_interrupt_3_o(), .timer_ext_clock_c_o(),
      .ext_interrupt_2_o());
   always #5 clk_i = ~clk_i;
   // master waits for ack with no cycle count; the watchdog ends a hang
   task wb(input logic w, input logic [31:0] a, input logic [31:0] d,
           input logic [3:0] s);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w;
      adr_i <= a; dat_i <= d; sel_i <= s;
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      q2 = dat_o2;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
   endtask
   task rchk(input logic [31:0] a, input logic [15:0] e);
      wb(1'b0, a, 32'h0, 4'hf);
      `CHK("read", {16'h0000, e}, q)
   endtask
   task pchk(input logic [15:0] eoe, input logic [15:0] eo);
      repeat (3) @(posedge clk_i);
      `CHK("pin_oe", eoe, pin_oe_o)
      `CHK("pin", eo & eoe, pin_o & eoe)
   endtask
   task do_reset(input logic ext);
      @(posedge clk_i);
      rst_i <= 1'b1; ext_i <= ext;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task results;
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      miscompares++;
      results();
   end
   initial begin
      clk_i = 0; rst_i = 1; cyc_i = 0; stb_i = 0; we_i = 0; ext_i = 1;
      rom_i = 0; adr_i = 0; dat_i = 0; sel_i = 0; pin_i = 0; dout = 0;
      per = 0; miscompares = 0; checks_done = 0;
      do_reset(1'b1);
      rchk(CTL, 16'h4000);
      rchk(DIR, 16'h0000);
      rchk(32'h0000_0100, 16'h0000);
      $display("test reset done");
      wb(1'b1, DIR, 32'h0000_ffff, 4'hf);
      rchk(DIR, 16'hffff);
      `CHK("read_rp", 32'h0000_83ff, q2)
      wb(1'b1, DIR, 32'h0000_1234, 4'h1);
      rchk(DIR, 16'hff34);
      wb(1'b1, DIR, 32'h0000_5600, 4'h2);
      rchk(DIR, 16'h5634);
      wb(1'b1, CTL, 32'h0000_ffff, 4'hf);
      rchk(CTL, 16'h555f);
      `CHK("read_rp", 32'h0000_400f, q2)
      $display("test registers done");
      wb(1'b1, DIR, 32'h0000_00ff, 4'hf);
      wb(1'b1, CTL, 32'h0000_0000, 4'hf);
      dout <= 16'ha5a5;
      pchk(16'h00ff, 16'h00a5);
      per <= 6'b101010;
      wb(1'b1, CTL, 32'h0000_5550, 4'hf);
      pchk(16'hfcff, 16'ha8a5);
      `CHK("oe_rp", 16'h80ff, oe2)
      ext_i <= 1'b0;
      pchk(16'h80ff, 16'h80a5);
      wb(1'b1, CTL, 32'h0000_0000, 4'hf);
      rom_i <= 1'b1;
      pchk(16'h7cff, 16'h28a5);
      `CHK("oe_rp", 16'h00ff, oe2)
      rom_i <= 1'b0;
      $display("test pin functions done");
      pin_i <= 16'h0300;
      for (int c = 0; c < 4; c++) begin
         wb(1'b1, CTL, {28'h0, c[1:0], c[1:0]}, 4'hf);
         repeat (3) @(posedge clk_i);
         efn = {c == 1, c == 2, c == 1, c == 2};
         `CHK("fn", efn, fn)
      end
      `CHK("din", 16'h0300, din)
      $display("test input functions done");
      do_reset(1'b0);
      rchk(CTL, 16'h0000);
      rchk(DIR, 16'h0000);
      $display("test second reset done");
      results();
   end
endmodule // tb_top
`default_nettype wire
